// >>> hw/pack_protect_pkg.sv
package pack_protect_pkg;

	// ****************************************
	// clock and time
	// ****************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int NS_PER_MS = 1000000;
	localparam int CYC_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;
	localparam logic [15:0] OC_BLANK_MS = 16'd50;
	localparam logic [15:0] PWR_DELAY_MS = 16'd400;
	localparam logic [15:0] CHG_OFF_MS = 16'd60000;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DIS_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_CHG_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_BLANK = 8'h0c;
	localparam logic [7:0] ADDR_CURRENT = 8'h10;
	localparam logic [15:0] DIS_LIMIT_RST = 16'd21250;
	localparam logic [15:0] CHG_LIMIT_RST = 16'd10000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DISCH = 3'b001,
		ST_CHG = 3'b010,
		ST_BLANK = 3'b011,
		ST_RECHK = 3'b100,
		ST_SHUT = 3'b101
	} sup_state_t;

	typedef struct packed {
		logic [21:0] zero;
		logic oc_pending;
		logic driver_power_en;
		logic power_off_n;
		logic discharge_switch;
		logic charge_switch;
		logic fault;
		logic dir_charge;
		sup_state_t state;
	} status_t;

endpackage

// >>> hw/pack_protect_supervisor.sv
`timescale 1ns/10ps
// Notes on behaviour
// - falling load sense edge enters the discharge routine.
// - rising charger sense edge enters the charging routine.
// - on alert, clear pending flag, blank 50 ms, then request a fresh reading.
// - fresh reading above the discharge limit after blanking records fault, drops both switches, pulls power-off low.
// - discharge-state readings are checked against the discharge limit unless an alert is pending or a sense edge arrives; violation faults and shuts down.
// - discharge alert and limit checks act only while direction is discharge.
// - while charging, reading below minus charge limit faults and shuts down.
// - limits reset to 21.25 A and 10 A and stay software adjustable.
// - driver power is removed about 400 ms after alert or power-off goes low.
// - entering charging turns both pack switches on.
// - about 60 s after charger removal both switches turn off.
module pack_protect_supervisor
	import pack_protect_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// board detect and monitor pins
	input wire logic load_sense_n,
	input wire logic charger_sense,
	input wire logic overcurrent_irq_n,
	input wire logic hw_overcurrent_alert_n,
	// current readings, signed milliamps, positive is discharge
	input wire logic signed [15:0] current_reading,
	input wire logic current_valid,
	output logic read_request,
	// switch and driver controls
	output logic charge_switch,
	output logic discharge_switch,
	output logic fet_driver_power_off_n,
	output logic driver_power_en,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	// order: load, charger, irq, hw alert; stage a feeds only stage b
	logic [3:0] sync_a_r, sync_b_r, sync_c_r;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync_a_r <= 4'hd;
			sync_b_r <= 4'hd;
			sync_c_r <= 4'hd;
		end else begin
			sync_a_r <= {hw_overcurrent_alert_n, overcurrent_irq_n, charger_sense, load_sense_n};
			sync_b_r <= sync_a_r;
			sync_c_r <= sync_b_r;
		end
	end

	logic load_edge, chg_edge, irq_edge, chg_level, alert_level_n;
	assign load_edge = sync_c_r[0] && !sync_b_r[0];
	assign chg_edge = !sync_c_r[1] && sync_b_r[1];
	assign irq_edge = sync_c_r[2] && !sync_b_r[2];
	assign chg_level = sync_b_r[1];
	assign alert_level_n = sync_b_r[3];

	// ****************************************
	// supervisor state
	// ****************************************
	sup_state_t state_r, state_nxt;
	logic dir_r, dir_nxt, fault_r, fault_nxt, pend_r, pend_nxt;
	logic cs_r, cs_nxt, ds_r, ds_nxt, poff_n_r, poff_n_nxt, pwr_r, pwr_nxt, req_r, req_nxt;
	logic [31:0] pre_r, pre_nxt;
	logic [15:0] blank_cnt_r, blank_cnt_nxt, pwr_cnt_r, pwr_cnt_nxt, off_cnt_r, off_cnt_nxt;
	logic signed [15:0] cur_r, cur_nxt;
	logic [15:0] dis_lim_r, dis_lim_nxt, chg_lim_r, chg_lim_nxt, blank_ms_r, blank_ms_nxt;
	logic ms_tick, dis_over, chg_over;

	assign ms_tick = (pre_r == 32'(CYC_PER_MS - 1));
	assign dis_over = 17'(signed'(current_reading)) > signed'({1'b0, dis_lim_r});
	assign chg_over = 17'(signed'(current_reading)) < -signed'({1'b0, chg_lim_r});

	// ****************************************
	// bus state
	// ****************************************
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [7:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic do_write;
	status_t stat;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [15:0] m;
		m = old;
		if (be[0]) m[7:0] = d[7:0];
		if (be[1]) m[15:8] = d[15:8];
		return m;
	endfunction

	always_comb begin
		stat = '0;
		stat.oc_pending = pend_r;
		stat.driver_power_en = pwr_r;
		stat.power_off_n = poff_n_r;
		stat.discharge_switch = ds_r;
		stat.charge_switch = cs_r;
		stat.fault = fault_r;
		stat.dir_charge = dir_r;
		stat.state = state_r;
	end

	assign do_write = aw_got_r && w_got_r && !bvalid_r;

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		dis_lim_nxt = dis_lim_r;
		chg_lim_nxt = chg_lim_r;
		blank_ms_nxt = blank_ms_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			waddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			unique case (waddr_r)
				ADDR_DIS_LIMIT: dis_lim_nxt = merge16(dis_lim_r, wdata_r, wstrb_r);
				ADDR_CHG_LIMIT: chg_lim_nxt = merge16(chg_lim_r, wdata_r, wstrb_r);
				ADDR_BLANK: blank_ms_nxt = merge16(blank_ms_r, wdata_r, wstrb_r);
				ADDR_STATUS, ADDR_CURRENT: ;
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_STATUS: rdata_nxt = stat;
				ADDR_DIS_LIMIT: rdata_nxt = {16'h0000, dis_lim_r};
				ADDR_CHG_LIMIT: rdata_nxt = {16'h0000, chg_lim_r};
				ADDR_BLANK: rdata_nxt = {16'h0000, blank_ms_r};
				ADDR_CURRENT: rdata_nxt = {{16{cur_r[15]}}, cur_r};
				default: begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// ****************************************
	// supervisor next state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		dir_nxt = dir_r;
		fault_nxt = fault_r;
		cs_nxt = cs_r;
		ds_nxt = ds_r;
		poff_n_nxt = poff_n_r;
		req_nxt = 1'b0;
		cur_nxt = current_valid ? current_reading : cur_r;
		pre_nxt = ms_tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
		blank_cnt_nxt = blank_cnt_r;
		off_cnt_nxt = off_cnt_r;
		pend_nxt = pend_r;
		// a fresh alert in the clearing cycle still lands, except in ST_SHUT where pending is always cleared
		if (irq_edge) pend_nxt = 1'b1;
		// driver power decays after a low alert or power-off
		pwr_cnt_nxt = pwr_cnt_r;
		pwr_nxt = pwr_r;
		if (!alert_level_n || !poff_n_r) begin
			if (pwr_cnt_r >= PWR_DELAY_MS) pwr_nxt = 1'b0;
			else if (ms_tick) pwr_cnt_nxt = pwr_cnt_r + 16'h0001;
		end else begin
			pwr_cnt_nxt = 16'h0000;
			pwr_nxt = 1'b1;
		end
		unique case (state_r)
			ST_IDLE, ST_DISCH, ST_CHG: begin
				if (chg_edge) begin
					state_nxt = ST_CHG;
					dir_nxt = 1'b1;
					cs_nxt = 1'b1;
					ds_nxt = 1'b1;
					off_cnt_nxt = 16'h0000;
				end else if (load_edge) begin
					state_nxt = ST_DISCH;
					dir_nxt = 1'b0;
					cs_nxt = 1'b1;
					ds_nxt = 1'b1;
				end else if (state_r == ST_DISCH) begin
					if (pend_r && !dir_r) begin
						state_nxt = ST_BLANK;
						pend_nxt = irq_edge;
						blank_cnt_nxt = 16'h0000;
					end else if (current_valid && !dir_r && dis_over) begin
						fault_nxt = 1'b1;
						state_nxt = ST_SHUT;
					end
				end else if (state_r == ST_CHG) begin
					pend_nxt = irq_edge;
					if (current_valid && dir_r && chg_over) begin
						fault_nxt = 1'b1;
						state_nxt = ST_SHUT;
					end else if (chg_level) begin
						off_cnt_nxt = 16'h0000;
					end else if (off_cnt_r >= CHG_OFF_MS) begin
						state_nxt = ST_IDLE;
						cs_nxt = 1'b0;
						ds_nxt = 1'b0;
					end else if (ms_tick) begin
						off_cnt_nxt = off_cnt_r + 16'h0001;
					end
				end
			end
			ST_BLANK: begin
				if (blank_cnt_r >= blank_ms_r) begin
					state_nxt = ST_RECHK;
					req_nxt = 1'b1;
				end else if (ms_tick) begin
					blank_cnt_nxt = blank_cnt_r + 16'h0001;
				end
			end
			ST_RECHK: begin
				if (current_valid) begin
					if (!dir_r && dis_over) begin
						fault_nxt = 1'b1;
						state_nxt = ST_SHUT;
					end else begin
						state_nxt = ST_DISCH;
					end
				end
			end
			ST_SHUT: begin
				pend_nxt = 1'b0;
			end
			default: state_nxt = ST_SHUT;
		endcase
		if (state_nxt == ST_SHUT) begin
			cs_nxt = 1'b0;
			ds_nxt = 1'b0;
			poff_n_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			dir_r <= 1'b0;
			fault_r <= 1'b0;
			pend_r <= 1'b0;
			cs_r <= 1'b0;
			ds_r <= 1'b0;
			poff_n_r <= 1'b1;
			pwr_r <= 1'b1;
			req_r <= 1'b0;
			pre_r <= 32'h0000_0000;
			blank_cnt_r <= 16'h0000;
			pwr_cnt_r <= 16'h0000;
			off_cnt_r <= 16'h0000;
			cur_r <= 16'sh0000;
			dis_lim_r <= DIS_LIMIT_RST;
			chg_lim_r <= CHG_LIMIT_RST;
			blank_ms_r <= OC_BLANK_MS;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else begin
			state_r <= state_nxt;
			dir_r <= dir_nxt;
			fault_r <= fault_nxt;
			pend_r <= pend_nxt;
			cs_r <= cs_nxt;
			ds_r <= ds_nxt;
			poff_n_r <= poff_n_nxt;
			pwr_r <= pwr_nxt;
			req_r <= req_nxt;
			pre_r <= pre_nxt;
			blank_cnt_r <= blank_cnt_nxt;
			pwr_cnt_r <= pwr_cnt_nxt;
			off_cnt_r <= off_cnt_nxt;
			cur_r <= cur_nxt;
			dis_lim_r <= dis_lim_nxt;
			chg_lim_r <= chg_lim_nxt;
			blank_ms_r <= blank_ms_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign read_request = req_r;
	assign charge_switch = cs_r;
	assign discharge_switch = ds_r;
	assign fet_driver_power_off_n = poff_n_r;
	assign driver_power_en = pwr_r;
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

endmodule

// >>> test/pack_protect_sva.sv
`timescale 1ns/10ps
// ********
// supervisor checks
// ********
module pack_protect_sva
	import pack_protect_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = 10
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// pins
	input wire logic load_sense_n,
	input wire logic charger_sense,
	input wire logic overcurrent_irq_n,
	input wire logic hw_overcurrent_alert_n,
	input wire logic read_request,
	// controls
	input wire logic charge_switch,
	input wire logic discharge_switch,
	input wire logic fet_driver_power_off_n,
	input wire logic driver_power_en
);
	// margins cover the free-running ms prescaler and the pin synchronisers
	localparam int BLANK_MIN = 48 * CYC_PER_MS;
	localparam int PWR_MIN = 398 * CYC_PER_MS;
	localparam int PWR_MAX = 402 * CYC_PER_MS + 20;
	int low_r, low_nxt, irq_r, irq_nxt;
	logic irq_q_r;
	always_comb begin
		low_nxt = (!hw_overcurrent_alert_n || !fet_driver_power_off_n) ? low_r + 1 : 0;
		irq_nxt = (irq_q_r && !overcurrent_irq_n) ? 0 : ((irq_r < 1000000) ? irq_r + 1 : irq_r);
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_r <= 0;
			irq_r <= 1000000;
			irq_q_r <= 1'b1;
		end else begin
			low_r <= low_nxt;
			irq_r <= irq_nxt;
			irq_q_r <= overcurrent_irq_n;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	shut_switches_a: assert property (!fet_driver_power_off_n |-> !charge_switch && !discharge_switch)
		else $error("switch on during shutdown");
	shut_sticky_a: assert property (!fet_driver_power_off_n |=> !fet_driver_power_off_n)
		else $error("power-off released");
	request_pulse_a: assert property (read_request |=> !read_request)
		else $error("read request longer than one cycle");
	blank_wait_a: assert property (read_request |-> irq_r >= BLANK_MIN)
		else $error("read request before blanking ended");
	power_min_a: assert property ($fell(driver_power_en) |-> low_r >= PWR_MIN)
		else $error("driver power removed early");
	power_max_a: assert property (low_r > PWR_MAX |-> !driver_power_en)
		else $error("driver power kept too long");
	charge_on_a: assert property ($rose(charger_sense) && fet_driver_power_off_n |-> ##[2:6] charge_switch && discharge_switch)
		else $error("charger not served");
	load_on_a: assert property ($fell(load_sense_n) && fet_driver_power_off_n |-> ##[2:6] discharge_switch)
		else $error("load not served");
endmodule

// >>> test/pack_monitor_model.sv
`timescale 1ns/10ps
// ********
// power monitor model: answers a fresh-reading request four cycles late
// ********
module pack_monitor_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// bench control
	input wire logic oc_event,
	input wire logic send_now,
	input wire logic signed [15:0] reply_ma,
	// supervisor side
	input wire logic read_request,
	output logic overcurrent_irq_n,
	output logic hw_overcurrent_alert_n,
	output logic signed [15:0] current_reading,
	output logic current_valid
);
	logic [2:0] wait_r, wait_nxt;
	logic valid_nxt;
	logic signed [15:0] read_nxt;
	assign overcurrent_irq_n = !oc_event;
	assign hw_overcurrent_alert_n = !oc_event;
	always_comb begin
		wait_nxt = {wait_r[1:0], read_request};
		valid_nxt = send_now || wait_r[2];
		// stale data is inverted so it never looks valid by accident
		read_nxt = valid_nxt ? reply_ma : ~current_reading;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wait_r <= 3'h0;
			current_valid <= 1'b0;
			current_reading <= 16'sh0;
		end else begin
			wait_r <= wait_nxt;
			current_valid <= valid_nxt;
			current_reading <= read_nxt;
		end
	end
endmodule

// >>> test/tb.sv
`timescale 1ns/10ps
// ********
// supervisor bench
// ********
module tb
	import pack_protect_pkg::*;
;
	logic sys_clk, nrst, load_sense_n, charger_sense, oc_event, send_now, irq_n, alert_n, cur_v, rreq;
	logic signed [15:0] reply_ma, cur;
	logic cs, ds, poff_n, pwr_en;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int bad_count, compares, n;
	// one clock per ms keeps the 60 s charger timeout inside the run; the prescaler divide is not exercised
	pack_protect_supervisor #(.CYC_PER_MS(1)) dut (.sys_clk(sys_clk), .nrst(nrst), .load_sense_n(load_sense_n),
		.charger_sense(charger_sense), .overcurrent_irq_n(irq_n), .hw_overcurrent_alert_n(alert_n),
		.current_reading(cur), .current_valid(cur_v), .read_request(rreq), .charge_switch(cs),
		.discharge_switch(ds), .fet_driver_power_off_n(poff_n), .driver_power_en(pwr_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	pack_monitor_model mon (.sys_clk(sys_clk), .nrst(nrst), .oc_event(oc_event), .send_now(send_now),
		.reply_ma(reply_ma), .read_request(rreq), .overcurrent_irq_n(irq_n), .hw_overcurrent_alert_n(alert_n),
		.current_reading(cur), .current_valid(cur_v));
	always #2.5 sys_clk = ~sys_clk;
	task automatic end_of_test();
		$display("errors %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic guard(input logic ok);
		if (!ok) begin
			bad_count++;
			$display("MISMATCH %0t wait timed out", $time);
			end_of_test();
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		logic ta, tw, tb_;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge sys_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb_ = bvalid;
			rsp = bresp;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb_) break;
		end
		guard(n < 50);
		bready <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		logic ta, tr;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge sys_clk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			rsp = rresp;
			@(posedge sys_clk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		guard(n < 50);
		rready <= 1'b0;
		cyc(1);
	endtask
	task automatic reading(input logic signed [15:0] v);
		reply_ma <= v;
		send_now <= 1'b1;
		cyc(1);
		send_now <= 1'b0;
		cyc(4);
	endtask
	// fault, direction and state fields of the status word
	task automatic st(input logic [4:0] e);
		rd(ADDR_STATUS, d, r);
		chk(32'(d[4:0]), 32'(e), "status");
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		load_sense_n <= 1'b1;
		charger_sense <= 1'b0;
		oc_event <= 1'b0;
		cyc(3);
		nrst <= 1'b1;
		cyc(1);
	endtask
	task automatic wait_req();
		for (n = 0; n < 700 && rreq !== 1'b1; n++) @(negedge sys_clk);
		guard(n < 700);
		cyc(6);
	endtask
	task automatic t_limits();
		do_reset();
		rd(ADDR_DIS_LIMIT, d, r);
		chk(d, 32'(DIS_LIMIT_RST), "discharge limit");
		rd(ADDR_CHG_LIMIT, d, r);
		chk(d, 32'(CHG_LIMIT_RST), "charge limit");
		rd(ADDR_BLANK, d, r);
		chk(d, 32'(OC_BLANK_MS), "blanking time");
		rd(8'h14, d, r);
		chk(d, 32'h0, "unmapped read data");
		chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
		wr(8'h14, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
		wr(ADDR_DIS_LIMIT, 32'd1000, r);
		load_sense_n <= 1'b0;
		cyc(8);
		st({2'b00, ST_DISCH});
		reading(16'sd1000);
		st({2'b00, ST_DISCH});
		reading(16'sd1001);
		st({2'b10, ST_SHUT});
		rd(ADDR_CURRENT, d, r);
		chk(d, 32'd1001, "last reading");
		chk(32'({cs, ds, poff_n}), 32'h0, "shutdown outputs");
	endtask
	task automatic t_charge();
		do_reset();
		charger_sense <= 1'b1;
		cyc(8);
		chk(32'({cs, ds}), 32'h3, "charge switches");
		st({2'b01, ST_CHG});
		oc_event <= 1'b1;
		// sampled off the clock edge so the count is not racing the register update
		for (n = 0; n < 600 && pwr_en !== 1'b0; n++) @(negedge sys_clk);
		guard(n < 600);
		chk(32'(n >= int'(PWR_DELAY_MS) && n <= int'(PWR_DELAY_MS) + 5), 32'h1, "alert power delay");
		cyc(1);
		oc_event <= 1'b0;
		reading(16'sd30000);
		st({2'b01, ST_CHG});
		reading(-16'sd10000);
		st({2'b01, ST_CHG});
		charger_sense <= 1'b0;
		for (n = 0; n < 61000 && cs !== 1'b0; n++) @(negedge sys_clk);
		guard(n < 61000);
		chk(32'(n >= int'(CHG_OFF_MS) && n <= int'(CHG_OFF_MS) + 5), 32'h1, "charger off delay");
		cyc(1);
		st({2'b01, ST_IDLE});
		charger_sense <= 1'b1;
		cyc(8);
		chk(32'({cs, ds}), 32'h3, "charger back");
		reading(-16'sd10001);
		st({2'b11, ST_SHUT});
		charger_sense <= 1'b0;
		cyc(10);
		chk(32'({cs, ds, poff_n}), 32'h0, "stays off");
	endtask
	task automatic t_oc_irq();
		do_reset();
		load_sense_n <= 1'b0;
		cyc(8);
		reply_ma <= 16'sd100;
		oc_event <= 1'b1;
		wait_req();
		oc_event <= 1'b0;
		st({2'b00, ST_DISCH});
		chk(32'({cs, ds}), 32'h3, "false alarm");
		reply_ma <= 16'sd30000;
		oc_event <= 1'b1;
		wait_req();
		st({2'b10, ST_SHUT});
		chk(32'({cs, ds, poff_n}), 32'h0, "oc shutdown");
		chk(32'(pwr_en), 32'h1, "driver power held");
		for (n = 0; n < 600 && pwr_en !== 1'b0; n++) @(negedge sys_clk);
		guard(n < 600);
		cyc(1);
		load_sense_n <= 1'b1;
		// long enough for the alert-low counter to pass the checker's upper bound
		cyc(40);
		chk(32'({cs, ds, poff_n}), 32'h0, "stays off");
	endtask
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		{load_sense_n, charger_sense, oc_event, send_now, reply_ma} = {1'b1, 19'h0};
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		bad_count = 0;
		compares = 0;
		t_limits();
		t_charge();
		t_oc_irq();
		end_of_test();
	end
endmodule
bind pack_protect_supervisor pack_protect_sva #(.CYC_PER_MS(CYC_PER_MS)) sva_i (.sys_clk(sys_clk), .nrst(nrst),
	.load_sense_n(load_sense_n), .charger_sense(charger_sense), .overcurrent_irq_n(overcurrent_irq_n),
	.hw_overcurrent_alert_n(hw_overcurrent_alert_n), .read_request(read_request), .charge_switch(charge_switch),
	.discharge_switch(discharge_switch), .fet_driver_power_off_n(fet_driver_power_off_n),
	.driver_power_en(driver_power_en));
